// *** logic/spe_host.sv ***
`timescale 1ns/1ps
// What this block does
// - Clock, data low, then raise entry pin
// - Configure write control before a row erase
// - Select code memory, clear config space
// - Write enable before any row erase start
// - Set write enable before loading the row address
// - Add data erase when data protected
// - Data pin low during bulk erase
// - Hold fourth clock high for program time
// - Clock low ends erase, then discharge
// - Fixed core instruction order for row

// ---------------------------------------------------------------------------
// Programmer-side erase sequencer with APB control registers
// ---------------------------------------------------------------------------
module spe_host
  import spe_pkg::*;
#(
  parameter int SCLK_HALF = 4,
  parameter int CNT_W = 24,
  parameter int ENTRY_TIME_US = 100,
  parameter int PROG_TIME_US = 1000,
  parameter int DISCH_TIME_US = 100,
  parameter int BULK_TIME_US = 5000
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Programming pins.
  output logic programming_clock_pin,
  output logic programming_data_pin_o,
  output logic programming_data_pin_oe,
  input wire logic programming_data_pin_i,
  output logic high_voltage_entry_pin
);

  // -------------------------------------------------------------------------
  // Timing counts
  // -------------------------------------------------------------------------

  // Every time here is a least time, so each count rounds up.
  localparam int ENTRY_CYC =
    (ENTRY_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PROG_CYC =
    (PROG_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DISCH_CYC =
    (DISCH_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BULK_CYC =
    (BULK_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  initial begin
    if (ENTRY_CYC < 1 || PROG_CYC < 1 || DISCH_CYC < 1 || BULK_CYC < 1 ||
        BULK_CYC >= (1 << CNT_W) || PROG_CYC >= (1 << CNT_W) ||
        ENTRY_CYC >= (1 << CNT_W) || DISCH_CYC >= (1 << CNT_W)) begin
      $error("spe_host: timing counts do not fit CNT_W");
    end
  end

  // -------------------------------------------------------------------------
  // Declarations
  // -------------------------------------------------------------------------

  // Sequencer states, Gray coded along idle, entry, load, shift.
  typedef enum logic [1:0] {
    SPE_IDLE = 2'b00,
    SPE_ENTRY = 2'b01,
    SPE_LOAD = 2'b11,
    SPE_SHIFT = 2'b10
  } spe_state_t;

  spe_state_t state_q; // Sequencer state.
  spe_op_t op_q; // Operation in progress.
  logic [3:0] step_q; // Index of the word in the sequence.
  logic [CNT_W-1:0] ent_q; // Entry settle counter.
  logic vpp_req_q; // Software asks for program mode.
  logic cpd_q; // Software reports the data memory is protected.
  logic [21:0] addr_q; // Row address, any byte inside the row.
  logic [15:0] code_q; // Bulk erase option code.
  logic in_mode_q; // Program mode reached.
  logic done_q; // Sticky: an operation finished.
  logic err_q; // Sticky: a request was refused.
  logic pin_s1_q; // Data pin synchroniser, first stage.
  logic pin_s2_q; // Data pin synchroniser, second stage.
  logic go_row; // Row erase requested by this write.
  logic go_bulk; // Bulk erase requested by this write.
  logic wr_ctrl; // Control register write accepted.
  logic wr_stat; // Status register write accepted.
  logic ap_write; // Write at the access edge.
  logic code_ok; // Bulk code is one that the device knows.
  logic [15:0] code_tx; // Code as sent, protection erase added.
  logic [3:0] w_cmd; // Command of the current word.
  logic [15:0] w_pay; // Payload of the current word.
  logic w_last; // Current word is the final one.
  logic sh_start; // Start pulse to the shifter.
  logic sh_busy; // Shifter busy.
  logic sh_done; // Shifter finished a word.
  logic [CNT_W-1:0] hi_len; // Hold-high length of the final word.
  logic [CNT_W-1:0] lo_len; // Hold-low length of the final word.
  logic busy; // Any activity in progress.
  logic op_end; // Final word of the sequence completed.

  // -------------------------------------------------------------------------
  // APB decode
  // -------------------------------------------------------------------------

  // Writes take effect at the access edge, when pready is already high.
  assign ap_write = psel && penable && pwrite && pready;
  assign wr_ctrl = ap_write && (paddr == REG_CTRL);
  assign wr_stat = ap_write && (paddr == REG_STAT);
  assign go_row = wr_ctrl && pwdata[CTRL_ROW];
  assign go_bulk = wr_ctrl && pwdata[CTRL_BULK];
  assign busy = (state_q != SPE_IDLE);
  assign op_end = (state_q == SPE_SHIFT) && sh_done && w_last;

  // The answer is registered in the setup cycle, so every access is
  // one setup cycle and one access cycle with no wait states.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      if (psel && !penable) begin
        unique case (paddr)
          REG_CTRL: begin
            prdata[CTRL_VPP] <= vpp_req_q;
            prdata[CTRL_CPD] <= cpd_q;
          end
          REG_ADDR: prdata[21:0] <= addr_q;
          REG_CODE: prdata[15:0] <= code_q;
          REG_STAT: begin
            prdata[STAT_BUSY] <= busy;
            prdata[STAT_DONE] <= done_q;
            prdata[STAT_ERR] <= err_q;
            prdata[STAT_MODE] <= in_mode_q;
            prdata[STAT_PIN] <= pin_s2_q;
          end
          // Unmapped offsets read zero and signal an error.
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  // Software-written settings. Address and code are frozen while busy so
  // a sequence never mixes two values.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vpp_req_q <= 1'b0;
      cpd_q <= 1'b0;
      addr_q <= 22'h000000;
      code_q <= 16'h0000;
    end else begin
      if (wr_ctrl) begin
        vpp_req_q <= pwdata[CTRL_VPP];
        cpd_q <= pwdata[CTRL_CPD];
      end
      if (ap_write && paddr == REG_ADDR && !busy) begin
        addr_q <= pwdata[21:0];
      end
      if (ap_write && paddr == REG_CODE && !busy) begin
        code_q <= pwdata[15:0];
      end
    end
  end

  // Sticky status. Writing one clears a bit, but a new event in the same
  // cycle wins so it is never lost.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      if (op_end) begin
        done_q <= 1'b1;
      end else if (wr_stat && pwdata[STAT_DONE]) begin
        done_q <= 1'b0;
      end
      if ((go_row || go_bulk) &&
          (busy || !in_mode_q || (go_row && go_bulk) ||
           (go_bulk && !code_ok))) begin
        err_q <= 1'b1;
      end else if (wr_stat && pwdata[STAT_ERR]) begin
        err_q <= 1'b0;
      end
    end
  end

  // Data pin level, for software to observe; two stages before any use.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
    end else begin
      pin_s1_q <= programming_data_pin_i;
      pin_s2_q <= pin_s1_q;
    end
  end

  // -------------------------------------------------------------------------
  // Bulk code check
  // -------------------------------------------------------------------------

  always_comb begin
    code_ok = (code_q == CODE_CHIP) || (code_q == CODE_DATA) ||
              (code_q == CODE_BOOT) || (code_q == CODE_CFG) ||
              ((code_q[7:0] == CODE_BLK_LOW) &&
               (code_q[15:8] >> NUM_BLOCKS) == 8'h00 &&
               $onehot(code_q[15:8]));
  end

  assign code_tx = cpd_q ? (code_q | CODE_DATA) : code_q;

  // -------------------------------------------------------------------------
  // Word sequence
  // -------------------------------------------------------------------------

  // Each step yields one command and payload. The final word of both
  // sequences is a no-operation whose fourth clock carries the timing.
  always_comb begin
    w_cmd = CMD_CORE;
    w_pay = I_NOP;
    w_last = 1'b0;
    if (op_q == SPE_OP_ROW) begin
      unique case (step_q)
        4'd0: w_pay = I_SET_PGM;
        4'd1: w_pay = I_CLR_CFG;
        4'd2: w_pay = I_SET_WRITE_ENABLE_BIT;
        4'd3: w_pay = {I_MOVLW, 2'b00, addr_q[21:16]};
        4'd4: w_pay = I_TP_UPPER;
        4'd5: w_pay = {I_MOVLW, addr_q[15:8]};
        4'd6: w_pay = I_TP_HIGH;
        4'd7: w_pay = {I_MOVLW, addr_q[7:0]};
        4'd8: w_pay = I_TP_LOW;
        4'd9: w_pay = I_SET_FREE;
        4'd10: w_pay = I_SET_WR;
        ROW_LAST: w_last = 1'b1;
        default: w_last = 1'b1;
      endcase
    end else begin
      unique case (step_q)
        4'd0: w_pay = {I_MOVLW, BULK_HI_ADDR[23:16]};
        4'd1: w_pay = I_TP_UPPER;
        4'd2: w_pay = {I_MOVLW, BULK_HI_ADDR[15:8]};
        4'd3: w_pay = I_TP_HIGH;
        4'd4: w_pay = {I_MOVLW, BULK_HI_ADDR[7:0]};
        4'd5: w_pay = I_TP_LOW;
        4'd6: begin
          w_cmd = CMD_TBLWR;
          w_pay = {code_tx[15:8], code_tx[15:8]};
        end
        4'd7: w_pay = {I_MOVLW, BULK_LO_ADDR[7:0]};
        4'd8: w_pay = I_TP_LOW;
        4'd9: begin
          w_cmd = CMD_TBLWR;
          w_pay = {code_tx[7:0], code_tx[7:0]};
        end
        BULK_LAST: w_last = 1'b1;
        default: w_last = 1'b1;
      endcase
    end
  end

  // Hold lengths of the final word: a row erase stretches the fourth clock
  // high and then low for discharge; a bulk erase runs by itself after the
  // fourth falling edge, so only the low phase is stretched.
  always_comb begin
    if (op_q == SPE_OP_ROW) begin
      hi_len = CNT_W'(PROG_CYC);
      lo_len = CNT_W'(DISCH_CYC);
    end else begin
      hi_len = CNT_W'(SCLK_HALF);
      lo_len = CNT_W'(BULK_CYC);
    end
  end

  // -------------------------------------------------------------------------
  // Sequencer
  // -------------------------------------------------------------------------

  // Mode entry and exit, and walking through the words of an operation.
  // Mode changes are taken only while idle, so the entry pin never moves
  // in the middle of a word.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= SPE_IDLE;
      op_q <= SPE_OP_ROW;
      step_q <= 4'd0;
      ent_q <= '0;
      in_mode_q <= 1'b0;
      high_voltage_entry_pin <= 1'b0;
      sh_start <= 1'b0;
    end else begin
      sh_start <= 1'b0;
      unique case (state_q)
        SPE_IDLE: begin
          if (vpp_req_q && !in_mode_q) begin
            high_voltage_entry_pin <= 1'b1;
            ent_q <= CNT_W'(ENTRY_CYC);
            state_q <= SPE_ENTRY;
          end else if (!vpp_req_q && in_mode_q) begin
            high_voltage_entry_pin <= 1'b0;
            in_mode_q <= 1'b0;
          end else if (in_mode_q && (go_row ^ go_bulk) &&
                       (go_row || code_ok)) begin
            op_q <= go_bulk ? SPE_OP_BULK : SPE_OP_ROW;
            step_q <= 4'd0;
            state_q <= SPE_LOAD;
          end
        end
        SPE_ENTRY: begin
          if (ent_q > 1) begin
            ent_q <= ent_q - 1'b1;
          end else begin
            in_mode_q <= 1'b1;
            state_q <= SPE_IDLE;
          end
        end
        SPE_LOAD: begin
          if (!sh_busy && !sh_start) begin
            sh_start <= 1'b1;
            state_q <= SPE_SHIFT;
          end
        end
        SPE_SHIFT: begin
          if (sh_done) begin
            if (w_last) begin
              state_q <= SPE_IDLE;
            end else begin
              step_q <= step_q + 1'b1;
              state_q <= SPE_LOAD;
            end
          end
        end
      endcase
    end
  end

  // The data pin is driven at all times out of reset: low outside words, which keeps
  // it low for mode entry and during self-timed erases.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      programming_data_pin_oe <= 1'b0;
    end else begin
      programming_data_pin_oe <= 1'b1;
    end
  end

  // -------------------------------------------------------------------------
  // Serial shifter
  // -------------------------------------------------------------------------

  spe_shift #(
    .HALF(SCLK_HALF),
    .CNT_W(CNT_W)
  ) u_shift (
    .pclk(pclk),
    .presetn(presetn),
    .start(sh_start),
    .cmd(w_cmd),
    .payload(w_pay),
    .hold_en(w_last),
    .hi_len(hi_len),
    .lo_len(lo_len),
    .clk_o(programming_clock_pin),
    .data_o(programming_data_pin_o),
    .busy(sh_busy),
    .done(sh_done)
  );

endmodule // spe_host

// *** logic/spe_pkg.sv ***
// ---------------------------------------------------------------------------
// Shared constants of the serial erase sequencer
// ---------------------------------------------------------------------------
package spe_pkg;

  // System clock period in nanoseconds (50 MHz).
  localparam int CLK_PERIOD_NS = 20;

  // Byte offsets of the controller's own APB registers.
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_ADDR = 12'h004;
  localparam logic [11:0] REG_CODE = 12'h008;
  localparam logic [11:0] REG_STAT = 12'h00c;

  // Control register fields.
  localparam int CTRL_VPP = 0;
  localparam int CTRL_ROW = 1;
  localparam int CTRL_BULK = 2;
  localparam int CTRL_CPD = 3;

  // Status register fields.
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_ERR = 2;
  localparam int STAT_MODE = 3;
  localparam int STAT_PIN = 4;

  // Four-bit serial commands: core instruction and table write.
  localparam logic [3:0] CMD_CORE = 4'h0;
  localparam logic [3:0] CMD_TBLWR = 4'hc;

  // Core instruction payloads acting on the memory write control register, and the no-operation.
  localparam logic [15:0] I_SET_PGM = 16'h8ea6;
  localparam logic [15:0] I_CLR_CFG = 16'h9ca6;
  localparam logic [15:0] I_SET_WRITE_ENABLE_BIT = 16'h84a6;
  localparam logic [15:0] I_SET_FREE = 16'h88a6;
  localparam logic [15:0] I_SET_WR = 16'h82a6;
  localparam logic [15:0] I_NOP = 16'h0000;

  // Table pointer loading: literal move opcode and the three byte stores.
  localparam logic [7:0] I_MOVLW = 8'h0e;
  localparam logic [15:0] I_TP_UPPER = 16'h6ef8;
  localparam logic [15:0] I_TP_HIGH = 16'h6ef7;
  localparam logic [15:0] I_TP_LOW = 16'h6ef6;

  // Addresses of the two bulk erase option registers.
  localparam logic [23:0] BULK_HI_ADDR = 24'h3c0005;
  localparam logic [23:0] BULK_LO_ADDR = 24'h3c0004;

  // Bulk erase option codes.
  localparam logic [15:0] CODE_CHIP = 16'h3f8f;
  localparam logic [15:0] CODE_DATA = 16'h0084;
  localparam logic [15:0] CODE_BOOT = 16'h0081;
  localparam logic [15:0] CODE_CFG = 16'h0082;
  localparam logic [7:0] CODE_BLK_LOW = 8'h80;
  localparam int NUM_BLOCKS = 6;

  // Sequence shape.
  localparam logic [3:0] ROW_LAST = 4'd11;
  localparam logic [3:0] BULK_LAST = 4'd10;
  localparam logic [4:0] HOLD_BIT = 5'd3;
  localparam logic [4:0] WORD_BITS = 5'd20;

  // Operation selector.
  typedef enum logic {
    SPE_OP_ROW = 1'b0,
    SPE_OP_BULK = 1'b1
  } spe_op_t;

endpackage

// *** logic/spe_shift.sv ***
`timescale 1ns/1ps
// ---------------------------------------------------------------------------
// Serial word shifter with programmable hold on the fourth clock
// ---------------------------------------------------------------------------
module spe_shift
  import spe_pkg::*;
#(
  parameter int HALF = 4,
  parameter int CNT_W = 24
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Word request.
  input wire logic start,
  input wire logic [3:0] cmd,
  input wire logic [15:0] payload,
  input wire logic hold_en,
  input wire logic [CNT_W-1:0] hi_len,
  input wire logic [CNT_W-1:0] lo_len,
  // Serial pins.
  output logic clk_o,
  output logic data_o,
  // Progress.
  output logic busy,
  output logic done
);

  localparam logic [CNT_W-1:0] HALF_C = CNT_W'(HALF);

  initial begin
    if (HALF < 2 || CNT_W < 8) begin
      $error("spe_shift: HALF must be 2 or more, CNT_W 8 or more");
    end
  end

  logic [19:0] sh_q; // Word, shifted out least significant bit first.
  logic [4:0] bit_q; // Index of the clock in progress.
  logic [CNT_W-1:0] cnt_q; // Cycles left in the current phase.
  logic is_hold; // The fourth clock of a word that asks for a hold.

  assign is_hold = hold_en && (bit_q == HOLD_BIT);

  // Clock generator and shift register. Data is placed at the rising edge
  // and returned to low at the falling edge, so the far end sees a stable
  // bit throughout the high phase and the pin rests low between bits.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_q <= 20'h00000;
      bit_q <= 5'd0;
      cnt_q <= '0;
      clk_o <= 1'b0;
      data_o <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (!busy) begin
        if (start) begin
          sh_q <= {payload, cmd};
          bit_q <= 5'd0;
          cnt_q <= HALF_C;
          busy <= 1'b1;
        end
      end else if (cnt_q > 1) begin
        cnt_q <= cnt_q - 1'b1;
      end else if (!clk_o) begin
        // Low phase over: either the word is complete or the next bit rises.
        if (bit_q == WORD_BITS) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          clk_o <= 1'b1;
          data_o <= sh_q[0];
          cnt_q <= is_hold ? hi_len : HALF_C;
        end
      end else begin
        clk_o <= 1'b0;
        data_o <= 1'b0;
        sh_q <= {1'b0, sh_q[19:1]};
        bit_q <= bit_q + 1'b1;
        cnt_q <= is_hold ? lo_len : HALF_C;
      end
    end
  end

endmodule // spe_shift

// *** verification/spe_dev_model.sv ***
`timescale 1ns/1ps
// ---------------------------------------------------------------------------
// Behavioural target device on the serial pins
// ---------------------------------------------------------------------------
module spe_dev_model
  import spe_pkg::*;
(
  // Clock and pins.
  input wire logic pclk,
  input wire logic clk_pin,
  input wire logic data_pin,
  input wire logic hv_pin,
  output wire logic spare_pin
);
  // Shift state, device registers and what the bench inspects.
  logic [19:0] sr_q;
  logic [4:0] nbit_q = 5'h0;
  logic prev_q = 1'b0;
  logic armed_q = 1'b0;
  logic [7:0] wcon_q = 8'h0, wreg_q, blo_q, bhi_q, last_con;
  logic [23:0] tptr_q, last_row;
  logic [15:0] last_bulk;
  logic [5:0] prot_q = 6'h0;
  int n_words, n_rows, n_bulk, hi_run, hi_max, lo_run, gap;

  assign spare_pin = hv_pin ? 1'bz : 1'b0;

  // Core instructions and table writes act on the device registers.
  task automatic exec(input logic [19:0] w);
    n_words++;
    if (w[3:0] == CMD_TBLWR) begin
      if (tptr_q == BULK_HI_ADDR) bhi_q = w[11:4];
      if (tptr_q == BULK_LO_ADDR) begin
        blo_q = w[11:4];
        armed_q = 1'b1;
      end
    end else begin
      case (w[19:4])
        I_SET_PGM: wcon_q[7] = 1'b1;
        I_CLR_CFG: wcon_q[6] = 1'b0;
        I_SET_WRITE_ENABLE_BIT: wcon_q[2] = 1'b1;
        I_SET_FREE: wcon_q[4] = 1'b1;
        I_SET_WR: wcon_q[1] = 1'b1;
        I_TP_UPPER: tptr_q[23:16] = wreg_q;
        I_TP_HIGH: tptr_q[15:8] = wreg_q;
        I_TP_LOW: tptr_q[7:0] = wreg_q;
        default: if (w[19:12] == I_MOVLW) wreg_q = w[11:4];
      endcase
    end
  endtask

  // Erase launched on the fourth fall of any core instruction word.
  task automatic erase();
    if (wcon_q[1]) begin
      last_con = wcon_q;
      if (wcon_q[7] && !wcon_q[6] && wcon_q[2] && wcon_q[4] && prot_q == 0)
      begin
        last_row = tptr_q & ~24'h3f;
        n_rows++;
      end
      wcon_q[1] = 1'b0;
    end else if (armed_q) begin
      last_bulk = {bhi_q, blo_q};
      prot_q = prot_q & ~last_bulk[13:8];
      n_bulk++;
      armed_q = 1'b0;
    end
  endtask

  // Pins are sampled by the system clock; edges are found against prev_q.
  always @(posedge pclk) begin
    // Low time after the fourth fall of a word, taken at its fifth rise.
    if (hv_pin && clk_pin && !prev_q && nbit_q == 5'h4) gap = lo_run;
    hi_run = clk_pin ? hi_run + 1 : 0;
    lo_run = clk_pin ? 0 : lo_run + 1;
    if (hi_run > hi_max) hi_max = hi_run;
    if (hv_pin && clk_pin && !prev_q) begin
      sr_q[nbit_q] = data_pin;
      if (nbit_q == 5'h13) exec(sr_q);
      nbit_q = (nbit_q == 5'h13) ? 5'h0 : nbit_q + 5'h1;
    end
    if (hv_pin && !clk_pin && prev_q && nbit_q == 5'h4 && sr_q[3:0] == 4'h0)
      erase();
    if (!hv_pin) nbit_q = 5'h0;
    prev_q = clk_pin;
  end
endmodule // spe_dev_model

// *** verification/spe_host_props.sv ***
`timescale 1ns/1ps
// ---------------------------------------------------------------------------
// Port checker of the erase sequencer
// ---------------------------------------------------------------------------
module spe_host_props (
  // Clock, reset and bus.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Serial pins.
  input wire logic programming_clock_pin,
  input wire logic programming_data_pin_o,
  input wire logic programming_data_pin_oe,
  input wire logic high_voltage_entry_pin
);
  // One domain, so clock and reset are given once.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_entry;
    $rose(high_voltage_entry_pin) |->
      !programming_clock_pin && !programming_data_pin_o;
  endproperty
  a_entry: assert property (p_entry) else $error("entry with pins high");
  property p_idle;
    !high_voltage_entry_pin |-> !programming_clock_pin;
  endproperty
  a_idle: assert property (p_idle) else $error("clock outside mode");
  property p_low;
    !programming_clock_pin |-> !programming_data_pin_o;
  endproperty
  a_low: assert property (p_low) else $error("data high in low phase");
  property p_hi;
    $rose(programming_clock_pin) |-> programming_clock_pin [*4];
  endproperty
  a_hi: assert property (p_hi) else $error("short high phase");
  property p_lo;
    $fell(programming_clock_pin) |-> !programming_clock_pin [*4];
  endproperty
  a_lo: assert property (p_lo) else $error("short low phase");
  property p_rdy;
    psel && !penable |=> pready ##1 !pready;
  endproperty
  a_rdy: assert property (p_rdy) else $error("bad ready timing");
  property p_err;
    psel && !penable && paddr > 12'h00c |=> pslverr && prdata == 32'h0;
  endproperty
  a_err: assert property (p_err) else $error("unmapped not refused");
  property p_rd0;
    !pready |-> prdata == 32'h0;
  endproperty
  a_rd0: assert property (p_rd0) else $error("read data outside access");
  property p_oe;
    presetn |=> programming_data_pin_oe;
  endproperty
  a_oe: assert property (p_oe) else $error("data pin not driven");
endmodule // spe_host_props

bind spe_host spe_host_props u_props (
  .pclk, .presetn, .psel, .penable, .paddr, .prdata, .pready, .pslverr,
  .programming_clock_pin, .programming_data_pin_o,
  .programming_data_pin_oe, .high_voltage_entry_pin
);

// *** verification/spe_host_tb_top.sv ***
`timescale 1ns/1ps
// ---------------------------------------------------------------------------
// Self-checking bench of the erase sequencer
// ---------------------------------------------------------------------------
module spe_host_tb_top;
  import spe_pkg::*;
  // Hold and discharge length in cycles for the one microsecond set below.
  localparam int CYC = 1000 / CLK_PERIOD_NS;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, last_q = 1'b0, rerr;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, sclk, sd_o, sd_oe, hv;
  wire logic sd;
  int failures = 0, n_tests = 0;
  logic [15:0] codes [10] = '{16'h3f8f, 16'h0084, 16'h0081, 16'h0082,
    16'h0180, 16'h0280, 16'h0480, 16'h0880, 16'h1080, 16'h2080};

  // A released data wire shows the inverse of its last driven level.
  assign sd = sd_oe ? sd_o : ~last_q;
  always @(posedge pclk) if (sd_oe) last_q <= sd_o;
  initial forever #10 pclk = ~pclk;

  spe_host #(.ENTRY_TIME_US(1), .PROG_TIME_US(1), .DISCH_TIME_US(1),
    .BULK_TIME_US(1)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .programming_clock_pin(sclk), .programming_data_pin_o(sd_o),
    .programming_data_pin_oe(sd_oe), .programming_data_pin_i(sd),
    .high_voltage_entry_pin(hv));
  spe_dev_model dev_u (.pclk(pclk), .clk_pin(sclk), .data_pin(sd),
    .hv_pin(hv), .spare_pin());

  task automatic give_verdict();
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  // One APB transfer; read data and error are taken at the ready edge.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1) begin
      failures++;
      give_verdict();
    end
    rd = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle edge, so the next call never reassigns psel in this step.
    @(posedge pclk);
  endtask
  // Polls a status bit; running out of polls ends the run as failed.
  task automatic wait_bit(input int b);
    int i;
    i = 0;
    // Always read afresh: a stale word from an earlier access must not count.
    do begin
      apb(1'b0, REG_STAT, 32'h0);
      i++;
    end while (rd[b] !== 1'b1 && i < 4000);
    chk("status bit", 32'h1, {31'h0, rd[b]});
    if (rd[b] !== 1'b1) give_verdict();
  endtask
  task automatic t_regs();
    apb(1'b0, REG_STAT, 32'h0);
    chk("stat reset", 32'h0, rd);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped", 32'h1, {31'h0, rerr});
    apb(1'b1, REG_ADDR, 32'hffff_ffff);
    apb(1'b0, REG_ADDR, 32'h0);
    chk("addr", 32'h003f_ffff, rd);
    apb(1'b1, REG_CTRL, 32'h1);
    wait_bit(STAT_MODE);
    chk("hv pin", 32'h1, {31'h0, hv});
  endtask
  task automatic t_row();
    int w0;
    w0 = dev_u.n_words;
    apb(1'b1, REG_ADDR, 32'h0001_2345);
    apb(1'b1, REG_CTRL, 32'h3);
    apb(1'b1, REG_CTRL, 32'h3);
    wait_bit(STAT_DONE);
    chk("busy go", 32'h4, rd & 32'h4);
    chk("row", 32'h0001_2340, {8'h0, dev_u.last_row});
    chk("ctl", 32'h96, {24'h0, dev_u.last_con});
    chk("words", 32'hc, dev_u.n_words - w0);
    chk("hold", 32'h1, dev_u.hi_max >= CYC);
    chk("disch", 32'h1, dev_u.gap >= CYC);
    apb(1'b1, REG_STAT, 32'h6);
    apb(1'b0, REG_STAT, 32'h0);
    chk("idle", 32'h8, rd);
  endtask
  task automatic t_bulk(input logic [15:0] c, e, input logic [31:0] ctl);
    int b0;
    b0 = dev_u.n_bulk;
    apb(1'b1, REG_CODE, {16'h0, c});
    apb(1'b1, REG_CTRL, ctl);
    wait_bit(STAT_DONE);
    chk("code", {16'h0, e}, {16'h0, dev_u.last_bulk});
    chk("bulks", 32'h1, dev_u.n_bulk - b0);
    chk("bulk wait", 32'h1, dev_u.gap >= CYC);
    apb(1'b1, REG_STAT, 32'h6);
  endtask
  // Refused starts: an unknown code, then row and bulk together.
  task automatic t_bad();
    int b0;
    b0 = dev_u.n_bulk;
    apb(1'b1, REG_CODE, 32'h0083);
    apb(1'b1, REG_CTRL, 32'h5);
    apb(1'b0, REG_STAT, 32'h0);
    chk("bad code", 32'hc, rd & 32'hf);
    apb(1'b1, REG_STAT, 32'h4);
    apb(1'b1, REG_CTRL, 32'h7);
    apb(1'b0, REG_STAT, 32'h0);
    chk("two go", 32'hc, rd & 32'hf);
    chk("none", 32'h0, dev_u.n_bulk - b0);
    apb(1'b1, REG_STAT, 32'h4);
  endtask

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_row();
    t_bad();
    for (int k = 0; k < 10; k++) t_bulk(codes[k], codes[k], 32'h5);
    t_bulk(16'h0081, 16'h0085, 32'hd);
    give_verdict();
  end
endmodule // spe_host_tb_top
